// ==== hw/irc_pkg.sv ====
// Constants, types and register map of the input range and colour block.
// Assumes a 100 MHz register clock and samples in thousandths of mA or V.
`default_nettype none
package irc_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_KHZ   = 100000;
  localparam int unsigned T_SHOW_MS = 1500;
  localparam int unsigned T_HOLD_MS = 2000;
  localparam int unsigned SHOW_DEF  = T_SHOW_MS * CLK_KHZ;
  localparam int unsigned HOLD_DEF  = T_HOLD_MS * CLK_KHZ;
  localparam int unsigned CNT_W     = 28;
  // ---------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SLO  = 8'h04;
  localparam logic [7:0] OFS_SHI  = 8'h08;
  localparam logic [7:0] OFS_EXT  = 8'h0C;
  localparam logic [7:0] OFS_THR  = 8'h10;
  localparam logic [7:0] OFS_BAND = 8'h14;
  localparam logic [7:0] OFS_CMD  = 8'h18;
  localparam logic [7:0] OFS_PXY  = 8'h1C;
  localparam logic [7:0] OFS_STAT = 8'h20;
  localparam logic [7:0] OFS_RES  = 8'h24;
  localparam int unsigned F_SIG = 0;
  localparam int unsigned F_CRV = 4;
  localparam int unsigned F_SMO = 8;
  localparam int unsigned F_LUM = 12;
  localparam int unsigned F_RED = 16;
  localparam int unsigned F_REL = 17;
  localparam int unsigned F_ALM = 19;
  localparam int unsigned F_XTR = 20;
  localparam int unsigned F_FAL = 21;
  localparam int unsigned F_ACK = 22;
  localparam int unsigned F_HI  = 16;
  localparam int unsigned F_HUE = 12;
  localparam int unsigned F_COD = 8;
  localparam logic [1:0] CMD_ADD = 2'h1;
  localparam logic [1:0] CMD_MOD = 2'h2;
  localparam logic [1:0] CMD_DEL = 2'h3;
  // ---------------------------------------------------------------
  // Limits
  // ---------------------------------------------------------------
  localparam logic signed [15:0] VAL_MIN  = 16'hFC19;
  localparam logic signed [15:0] VAL_MAX  = 16'h270F;
  localparam logic signed [15:0] BAND_MAX = 16'h03E7;
  localparam logic signed [15:0] X_MAX    = 16'h07CF;
  localparam logic [9:0]         LOX_MAX  = 10'h3E7;
  localparam logic [9:0]         HIX_MAX  = 10'h0C7;
  localparam logic [2:0]         SMO_MAX  = 3'h5;
  localparam int                 PCT_DIV  = 1000;
  localparam logic [4:0]         MAX_PTS  = 5'h14;
  localparam logic [4:0]         MIN_PTS  = 5'h02;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SIG_I0_20 = 3'h0, SIG_I4_20 = 3'h1, SIG_V0_10 = 3'h2,
    SIG_V2_10 = 3'h3, SIG_V0_5 = 3'h4, SIG_V1_5 = 3'h5
  } irc_sig_e;
  typedef enum logic [1:0] {
    CRV_PROP = 2'h0, CRV_QUAD = 2'h1, CRV_ROOT = 2'h2, CRV_USER = 2'h3
  } irc_crv_e;
  typedef enum logic [3:0] {
    DSP_VAL = 4'h0, DSP_UNDER = 4'h1, DSP_OVER = 4'h2, DSP_OVF = 4'h3,
    DSP_FEW = 4'h4, DSP_DUP = 4'h5, DSP_CNT = 4'h6, DSP_ASK = 4'h7,
    DSP_X = 4'h8, DSP_Y = 4'h9, DSP_EDX = 4'hA, DSP_EDY = 4'hB
  } irc_dsp_e;
  typedef enum logic [4:0] {
    MS_IDLE = 5'h01, MS_CNT = 5'h02, MS_SEL = 5'h04, MS_ASK = 5'h08,
    MS_EDIT = 5'h10
  } irc_menu_e;
  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
  } irc_point_s;
  typedef struct packed {
    irc_sig_e   sig;
    irc_crv_e   crv;
    logic [2:0] smo;
    logic [2:0] lum;
    logic       red;
    logic [1:0] rel_en;
    logic       alm_en;
    logic       xtr_en;
    logic       fall;
    logic       ack_en;
  } irc_cfg_s;
  // Nominal span start and end, thousandths of mA or V
  function automatic int span_start(irc_sig_e s);
    unique case (s)
      SIG_I4_20: span_start = 32'h0FA0;
      SIG_V2_10: span_start = 32'h07D0;
      SIG_V1_5:  span_start = 32'h03E8;
      default:   span_start = 32'h0000;
    endcase
  endfunction
  function automatic int span_end(irc_sig_e s);
    unique case (s)
      SIG_I0_20, SIG_I4_20: span_end = 32'h4E20;
      SIG_V0_10, SIG_V2_10: span_end = 32'h2710;
      default:              span_end = 32'h1388;
    endcase
  endfunction
endpackage
`default_nettype wire

// ==== hw/irc_top.sv ====
// Input range checking, scaling, user curve points and colour signalling.
// Assumes samples from logic on ref_clk_i; keys and relays come from pins.
`timescale 1ns/10ps
`default_nettype none
module irc_top
  import irc_pkg::*;
#(
  parameter int unsigned SHOW_CYC = SHOW_DEF,
  parameter int unsigned HOLD_CYC = HOLD_DEF
) (
  // Clock and reset
  input  wire logic               ref_clk_i,
  input  wire logic               rst_n_i,
  // Avalon-MM slave
  input  wire logic [7:0]         avs_address_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic [31:0]        avs_writedata_i,
  input  wire logic [3:0]         avs_byteenable_i,
  output logic [31:0]             avs_readdata_o,
  output logic                    avs_waitrequest_o,
  // Input samples and pins: keys are esc, enter, down, up
  input  wire logic               adc_valid_i,
  input  wire logic signed [17:0] adc_value_i,
  input  wire logic [3:0]         keys_i,
  input  wire logic [1:0]         relay_i,
  // Display
  output var irc_dsp_e            disp_code_o,
  output logic signed [15:0]      disp_value_o,
  output logic                    hue_red_o,
  output logic [2:0]              luminance_o,
  output logic                    alarm_o
);
  typedef struct packed {
    irc_cfg_s                  cfg;
    logic signed [15:0]        slo, shi, thr, band;
    logic [9:0]                lox, hix;
    irc_point_s [19:0]         pts;
    irc_point_s                stg;
    logic [4:0]                npts, sel;
    irc_menu_e                 menu;
    logic                      del, sel_y, held;
    logic [CNT_W-1:0]          cnt;
    logic [5:0]                sy1, sy2, prv;
    logic signed [17:0]        smoothing_level;
    logic signed [15:0]        res, dval;
    irc_dsp_e                  dcode;
    logic                      dup, cond, hue, alm, wait_r;
    logic [3:0]                ev;
    logic [31:0]               rdata;
  } irc_state_s;

  irc_state_s q, n;
  logic [1:0] rst_sy;
  logic       rst_n;

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  // Two flops so release never meets a clock edge mid-design
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sy <= 2'h0;
    end else begin
      rst_sy <= {rst_sy[0], 1'b1};
    end
  end
  assign rst_n = rst_sy[1];

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic signed [15:0] clamp(int v, int lo, int hi);
    int t;
    t = (v < lo) ? lo : ((v > hi) ? hi : v);
    clamp = 16'(t);
  endfunction

  logic [3:0]  keys, kp;
  logic [1:0]  rel;
  logic [31:0] rmux, wm, bm;
  logic [3:0]  ev_set;
  logic        acc, wr_go, user, under, over, ovf, dupx, hit;
  int          st, en, lob, hib, num, wid, loc, hic, w, kx;

  always_comb begin
    n = q;
    st = span_start(q.cfg.sig);
    en = span_end(q.cfg.sig);
    user = (q.cfg.crv == CRV_USER);
    // Only the settled copy is read; first stage feeds it alone
    n.sy1 = {relay_i, keys_i};
    n.sy2 = q.sy1;
    n.prv = q.sy2;
    keys = q.sy2[3:0];
    rel = q.sy2[5:4];
    kp = keys & ~q.prv[3:0];

    // Smoothing: one-pole average, level five spans about two seconds
    if (adc_valid_i) begin
      n.smoothing_level = 18'(q.smoothing_level + ((19'(adc_value_i) - 19'(q.smoothing_level)) >>> q.cfg.smo));
    end

    // Permissible borders, extensions in tenths of a percent
    lob = st - (st * int'(q.lox)) / PCT_DIV;
    hib = en + (en * int'(q.hix)) / PCT_DIV;
    under = int'(q.smoothing_level) < lob;
    over = int'(q.smoothing_level) > hib;

    // Span limits come from the first and last point on the user curve once it holds at least two points
    hit = user && (q.npts >= MIN_PTS);
    loc = hit ? int'(q.pts[0].y) : int'(q.slo);
    hic = hit ? int'(q.pts[q.npts - 5'h01].y) : int'(q.shi);
    num = int'(q.smoothing_level) - st;
    wid = en - st;
    if (q.cfg.crv == CRV_QUAD) begin
      num = (num * num) / wid;
    end
    w = loc + (num * (hic - loc)) / wid;
    ovf = (w < int'(VAL_MIN)) || (w > int'(VAL_MAX));
    if (!ovf) begin
      n.res = 16'(w);
    end

    // Measurement display, warnings in priority order
    n.dval = q.res;
    if (user && q.npts < MIN_PTS) begin
      n.dcode = DSP_FEW;
    end else if (under) begin
      n.dcode = DSP_UNDER;
    end else if (over) begin
      n.dcode = DSP_OVER;
    end else if (ovf) begin
      n.dcode = DSP_OVF;
    end else begin
      n.dcode = DSP_VAL;
    end
    if (q.dup) begin
      n.dcode = DSP_DUP;
    end
    n.alm = under || over;

    // ---------------------------------------------------------------
    // Register bus: one wait cycle, then the answer edge
    // ---------------------------------------------------------------
    acc = (avs_read_i || avs_write_i) && q.wait_r;
    wr_go = avs_write_i && !q.wait_r;
    n.wait_r = !acc;
    unique case (avs_address_i)
      OFS_CTRL: rmux = 32'({q.cfg.ack_en, q.cfg.fall, q.cfg.xtr_en, q.cfg.alm_en, q.cfg.rel_en,
                            q.cfg.red, 1'b0, q.cfg.lum, 1'b0, q.cfg.smo, 2'h0, q.cfg.crv,
                            1'b0, q.cfg.sig});
      OFS_SLO:  rmux = 32'(signed'(16'(loc)));
      OFS_SHI:  rmux = 32'(signed'(16'(hic)));
      OFS_EXT:  rmux = {6'h00, q.hix, 6'h00, q.lox};
      OFS_THR:  rmux = 32'(q.thr);
      OFS_BAND: rmux = 32'(q.band);
      OFS_PXY:  rmux = {q.stg.y, q.stg.x};
      OFS_STAT: rmux = 32'({q.hue, q.dcode, 3'h0, q.npts});
      OFS_RES:  rmux = 32'(q.res);
      default:  rmux = 32'h0000_0000;
    endcase
    if (acc && avs_read_i) begin
      n.rdata = rmux;
    end
    bm = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
          {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    wm = (rmux & ~bm) | (avs_writedata_i & bm);
    dupx = 1'b0;
    for (int i = 0; i < 20; i++) begin
      if (5'(i) < q.npts && q.pts[i].x == q.stg.x) begin
        dupx = 1'b1;
      end
    end
    if (|kp) begin
      n.dup = 1'b0;
    end
    if (wr_go) begin
      unique case (avs_address_i)
        OFS_CTRL: begin
          n.cfg.sig = irc_sig_e'(wm[F_SIG +: 3] > 3'h5 ? 3'h5 : wm[F_SIG +: 3]);
          n.cfg.crv = irc_crv_e'(wm[F_CRV +: 2]);
          n.cfg.smo = (wm[F_SMO +: 3] > SMO_MAX) ? SMO_MAX : wm[F_SMO +: 3];
          n.cfg.lum = wm[F_LUM +: 3];
          n.cfg.red = wm[F_RED];
          n.cfg.rel_en = wm[F_REL +: 2];
          n.cfg.alm_en = wm[F_ALM];
          n.cfg.xtr_en = wm[F_XTR];
          n.cfg.fall = wm[F_FAL];
          n.cfg.ack_en = wm[F_ACK];
        end
        OFS_SLO: if (!user) n.slo = clamp(int'(signed'(wm[15:0])), VAL_MIN, VAL_MAX);
        OFS_SHI: if (!user) n.shi = clamp(int'(signed'(wm[15:0])), VAL_MIN, VAL_MAX);
        OFS_EXT: begin
          n.lox = (wm[9:0] > LOX_MAX) ? LOX_MAX : wm[9:0];
          n.hix = (wm[F_HI +: 10] > HIX_MAX) ? HIX_MAX : wm[F_HI +: 10];
        end
        OFS_THR:  n.thr = clamp(int'(signed'(wm[15:0])), VAL_MIN, VAL_MAX);
        OFS_BAND: n.band = clamp(int'(signed'(wm[15:0])), 0, BAND_MAX);
        OFS_PXY: begin
          n.stg.x = clamp(int'(signed'(wm[15:0])), VAL_MIN, X_MAX);
          n.stg.y = clamp(int'(signed'(wm[31:16])), VAL_MIN, VAL_MAX);
        end
        OFS_CMD: begin
          // Point options do nothing unless the user curve is chosen
          if (user && q.menu == MS_IDLE) begin
            if (wm[1:0] == CMD_ADD && q.npts < MAX_PTS) begin
              if (dupx) begin
                n.dup = 1'b1;
              end else begin
                n.pts[q.npts] = q.stg;
                n.npts = q.npts + 5'h01;
              end
            end else if (wm[1:0] == CMD_MOD || wm[1:0] == CMD_DEL) begin
              n.menu = MS_CNT;
              n.del = (wm[1:0] == CMD_DEL);
              n.cnt = '0;
              n.sel = 5'h00;
              n.sel_y = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end

    // ---------------------------------------------------------------
    // Point removal and modification from the keys
    // ---------------------------------------------------------------
    kx = int'(q.sel);
    unique case (q.menu)
      MS_IDLE: ;
      MS_CNT: begin
        n.dcode = DSP_CNT;
        n.dval = 16'(q.npts);
        n.cnt = q.cnt + 1'b1;
        if (q.cnt == CNT_W'(SHOW_CYC - 1)) begin
          n.menu = (q.npts == 5'h00) ? MS_IDLE : MS_SEL;
          n.cnt = '0;
        end
      end
      MS_SEL: begin
        n.dcode = q.sel_y ? DSP_Y : DSP_X;
        n.dval = q.sel_y ? q.pts[kx].y : q.pts[kx].x;
        if (kp[0] && q.sel < q.npts - 5'h01) n.sel = q.sel + 5'h01;
        if (kp[1] && q.sel != 5'h00) n.sel = q.sel - 5'h01;
        if (keys[2]) begin
          n.cnt = q.cnt + 1'b1;
          if (q.cnt == CNT_W'(HOLD_CYC - 1)) begin
            n.menu = q.del ? MS_ASK : MS_EDIT;
            n.cnt = '0;
          end
        end else begin
          n.cnt = '0;
          if (q.prv[2]) n.sel_y = !q.sel_y;
        end
      end
      MS_ASK: begin
        n.dcode = DSP_ASK;
        if (kp[2]) begin
          // Close the gap so the points stay packed from index zero
          for (int i = 0; i < 19; i++) begin
            if (i >= kx) n.pts[i] = q.pts[i + 1];
          end
          n.npts = q.npts - 5'h01;
          n.menu = MS_CNT;
          n.sel = 5'h00;
        end
      end
      MS_EDIT: begin
        n.dcode = q.sel_y ? DSP_EDY : DSP_EDX;
        n.dval = q.sel_y ? q.pts[kx].y : q.pts[kx].x;
        if (q.sel_y) begin
          if (kp[0]) n.pts[kx].y = clamp(int'(q.pts[kx].y) + 1, VAL_MIN, VAL_MAX);
          if (kp[1]) n.pts[kx].y = clamp(int'(q.pts[kx].y) - 1, VAL_MIN, VAL_MAX);
        end else begin
          if (kp[0]) n.pts[kx].x = clamp(int'(q.pts[kx].x) + 1, VAL_MIN, X_MAX);
          if (kp[1]) n.pts[kx].x = clamp(int'(q.pts[kx].x) - 1, VAL_MIN, X_MAX);
        end
        if (kp[2]) n.menu = MS_SEL;
      end
      default: n.menu = MS_IDLE;
    endcase
    if (kp[3]) n.menu = MS_IDLE;

    // ---------------------------------------------------------------
    // Colour events
    // ---------------------------------------------------------------
    // Hysteresis on the extra threshold, band applied on both sides
    if (q.cfg.fall ? (q.res < q.thr - q.band) : (q.res > q.thr + q.band)) begin
      n.cond = 1'b1;
    end else if (q.cfg.fall ? (q.res > q.thr + q.band) : (q.res < q.thr - q.band)) begin
      n.cond = 1'b0;
    end
    ev_set[0] = q.cfg.rel_en[0] && rel[0];
    ev_set[1] = q.cfg.rel_en[1] && rel[1];
    ev_set[2] = q.cfg.alm_en && q.alm;
    ev_set[3] = q.cfg.xtr_en && n.cond && !q.cond;
    // Set is applied after the clear so a new event is never lost
    if (q.cfg.ack_en && |kp) n.ev = 4'h0;
    n.ev = n.ev | ev_set;
    n.hue = q.cfg.red ^ (|q.ev);
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.menu <= MS_IDLE;
      q.wait_r <= 1'b1;
      q.cfg.lum <= 3'h7;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from the state flops
  assign avs_readdata_o = q.rdata;
  assign avs_waitrequest_o = q.wait_r;
  assign disp_code_o = q.dcode;
  assign disp_value_o = q.dval;
  assign hue_red_o = q.hue;
  assign luminance_o = q.cfg.lum;
  assign alarm_o = q.alm;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_span_lock: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (q.cfg.crv == CRV_USER && wr_go && avs_address_i == OFS_SLO) |=> $stable(q.slo))
    else $error("span start changed under user curve");
  chk_point_cap: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    q.npts <= MAX_PTS) else $error("point count above limit");
  chk_dup_refuse: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    $rose(q.dup) |-> (q.npts == $past(q.npts)) ##1 (q.dcode == DSP_DUP))
    else $error("duplicate point accepted or not shown");
  chk_few_points: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (q.menu == MS_IDLE && !q.dup && user && q.npts < MIN_PTS) |=> q.dcode == DSP_FEW)
    else $error("too few points not shown");
  chk_over_warn: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (q.menu == MS_IDLE && !q.dup && !user && over && !under) |=> q.dcode == DSP_OVER)
    else $error("over range not shown");
  chk_smooth_max: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    q.cfg.smo <= SMO_MAX) else $error("smoothing level above five");
  chk_ack_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (q.cfg.ack_en && |kp && ev_set == 4'h0) |=> (q.ev == 4'h0) ##1 (q.hue == $past(q.cfg.red)))
    else $error("acknowledge left an event");
  chk_relay_hue: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (ev_set[0] && !(q.cfg.ack_en && |kp)) |-> ##2 (q.hue != $past(q.cfg.red)))
    else $error("relay did not switch hue");
  chk_hold_ask: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (q.menu == MS_SEL && q.del && keys[2] && !kp[3] && q.cnt == CNT_W'(HOLD_CYC - 1))
    |=> q.menu == MS_ASK) else $error("long hold did not ask");
  chk_show_time: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (q.menu == MS_CNT) |-> q.cnt < CNT_W'(SHOW_CYC)) else $error("count shown too long");
endmodule
`default_nettype wire

// ==== verif/irc_keys_model.sv ====
// Operator model: holds front-panel keys for a set number of cycles.
// Assumes the bench clock; keys are active-high levels, released at rest.
`timescale 1ns/10ps
`default_nettype none
module irc_keys_model (
  // Clock and key pins
  input  wire logic       clk_i,
  output logic      [3:0] keys_o
);
  // All keys released from time zero
  initial keys_o = 4'h0;
  // Press one key n cycles, then leave time for the pin synchroniser
  task automatic press(input int k, input int n);
    keys_o[k] <= 1'b1;
    repeat (n) @(posedge clk_i);
    keys_o[k] <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ==== verif/irc_top_tb_top.sv ====
// Self-checking bench for irc_top: bus, samples, relays and keys.
// Assumes irc_pkg and irc_keys_model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CK(A, B) begin cmp_count++; if ((A) !== (B)) begin bad_count++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, A, B); end end
module irc_top_tb_top;
  import irc_pkg::*;
  // ---------------------------------------------------------------
  // Signals and design
  // ---------------------------------------------------------------
  logic               ref_clk_i = 1'b0;
  logic               rst_n_i   = 1'b0;
  logic               rd = 1'b0, wr = 1'b0, av = 1'b0;
  logic        [7:0]  adr = 8'h00;
  logic        [31:0] wd = 32'h0, q, rdat;
  logic signed [17:0] adc = 18'h0;
  logic        [1:0]  rel = 2'h0;
  wire logic   [3:0]  keys;
  logic               wreq, hue, alm;
  logic        [2:0]  lum;
  logic signed [15:0] dval;
  irc_dsp_e           code;
  int                 bad_count = 0, cmp_count = 0;
  // Short menu spans keep the run brief
  irc_top #(.SHOW_CYC(20), .HOLD_CYC(30)) dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .adc_valid_i(av), .adc_value_i(adc), .keys_i(keys), .relay_i(rel),
    .disp_code_o(code), .disp_value_o(dval), .hue_red_o(hue), .luminance_o(lum), .alarm_o(alm));
  irc_keys_model km (.clk_i(ref_clk_i), .keys_o(keys));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  // Hold the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge ref_clk_i);
    // Only the watchdog ends a wait that never sees the answer
    while (wreq !== 1'b0) @(posedge ref_clk_i);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // Bounded wait for a display code
  task automatic wc(input irc_dsp_e e);
    for (int i = 0; i < 80 && code !== e; i++) @(posedge ref_clk_i);
  endtask
  // One sample pulse, then wait for the expected display
  task automatic smp(input int v, input irc_dsp_e e);
    @(posedge ref_clk_i);
    adc <= 18'(v);
    av <= 1'b1;
    @(posedge ref_clk_i);
    av <= 1'b0;
    // Filter, result, hysteresis and hue each add an edge; judge only the new sample
    repeat (5) @(posedge ref_clk_i);
    wc(e);
  endtask
  // Counts, verdict and end of run
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_cfg();
    `CK(lum, 3'h7)
    bus(1, OFS_CTRL, 32'h0000_0707);
    bus(0, OFS_CTRL, 0);
    `CK(q[2:0], 3'h5)
    `CK(q[10:8], 3'h5)
    bus(1, OFS_SLO, 32'hFFFF_F000);
    bus(0, OFS_SLO, 0);
    `CK(q[15:0], VAL_MIN)
    $display("test cfg done");
  endtask
  task automatic t_range();
    bus(1, OFS_CTRL, 32'h1);
    bus(1, OFS_SLO, 0);
    bus(1, OFS_EXT, 0);
    smp(3000, DSP_UNDER);
    `CK(code, DSP_UNDER)
    `CK(alm, 1'b1)
    smp(21000, DSP_OVER);
    `CK(code, DSP_OVER)
    bus(1, OFS_EXT, 32'h0064_03E7);
    smp(3000, DSP_VAL);
    `CK(code, DSP_VAL)
    bus(1, OFS_SHI, 32'h270F);
    smp(20000, DSP_VAL);
    `CK(dval, 16'h270F)
    bus(1, OFS_EXT, 32'h00C7_03E7);
    smp(23000, DSP_OVF);
    `CK(code, DSP_OVF)
    bus(1, OFS_CTRL, 32'h0);
    smp(-1, DSP_UNDER);
    `CK(code, DSP_UNDER)
    $display("test range done");
  endtask
  task automatic t_hue();
    bus(1, OFS_CTRL, 32'h0043_2001);
    repeat (4) @(posedge ref_clk_i);
    `CK(hue, 1'b1)
    `CK(lum, 3'h2)
    rel <= 2'h1;
    repeat (6) @(posedge ref_clk_i);
    `CK(hue, 1'b0)
    rel <= 2'h0;
    repeat (6) @(posedge ref_clk_i);
    `CK(hue, 1'b0)
    km.press(0, 3);
    `CK(hue, 1'b1)
    bus(1, OFS_CTRL, 32'h0009_0001);
    smp(30000, DSP_OVER);
    repeat (4) @(posedge ref_clk_i);
    `CK(hue, 1'b0)
    $display("test hue done");
  endtask
  task automatic t_thr();
    bus(1, OFS_CTRL, 32'h0050_0001);
    bus(1, OFS_THR, 32'h1388);
    bus(1, OFS_BAND, 32'h64);
    smp(4000, DSP_VAL);
    km.press(3, 3);
    `CK(hue, 1'b0)
    smp(12081, DSP_VAL);
    `CK(hue, 1'b0)
    smp(13600, DSP_VAL);
    `CK(hue, 1'b1)
    km.press(3, 3);
    `CK(hue, 1'b0)
    bus(1, OFS_CTRL, 32'h0070_0001);
    smp(4000, DSP_VAL);
    `CK(hue, 1'b1)
    $display("test thr done");
  endtask
  task automatic t_user();
    bus(1, OFS_CTRL, 32'h1);
    bus(1, OFS_PXY, 32'h0064_0000);
    bus(1, OFS_CMD, CMD_ADD);
    bus(0, OFS_STAT, 0);
    `CK(q[4:0], 5'h0)
    bus(1, OFS_CTRL, 32'h31);
    smp(12000, DSP_FEW);
    `CK(code, DSP_FEW)
    bus(1, OFS_CMD, CMD_ADD);
    bus(1, OFS_CMD, CMD_ADD);
    wc(DSP_DUP);
    `CK(code, DSP_DUP)
    bus(1, OFS_PXY, 32'h00C8_03E8);
    bus(1, OFS_CMD, CMD_ADD);
    bus(1, OFS_SLO, 32'h01F4);
    bus(0, OFS_SLO, 0);
    `CK(q[15:0], 16'h0064)
    bus(0, OFS_STAT, 0);
    `CK(q[4:0], 5'h2)
    bus(1, OFS_CMD, CMD_DEL);
    wc(DSP_CNT);
    `CK(dval, 16'h0002)
    wc(DSP_X);
    `CK(code, DSP_X)
    km.press(2, 40);
    wc(DSP_ASK);
    `CK(code, DSP_ASK)
    km.press(2, 3);
    wc(DSP_CNT);
    `CK(dval, 16'h0001)
    wc(DSP_X);
    `CK(dval, 16'h03E8)
    km.press(2, 3);
    wc(DSP_Y);
    `CK(dval, 16'h00C8)
    km.press(3, 3);
    bus(1, OFS_CMD, CMD_MOD);
    wc(DSP_X);
    km.press(2, 40);
    wc(DSP_EDX);
    `CK(code, DSP_EDX)
    km.press(0, 3);
    `CK(dval, 16'h03E9)
    $display("test user done");
  endtask
  // ---------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ---------------------------------------------------------------
  initial forever #5 ref_clk_i = ~ref_clk_i;
  // Reset two cycles; the internal copy needs two more edges to release
  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    t_cfg();
    t_range();
    t_hue();
    t_thr();
    t_user();
    close_out();
  end
  // Whole run needs well under a thousand cycles; a hang ends here
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire
